// ### src/hpd_host_ctrl.sv
`timescale 1ns/1ps
module hpd_host_ctrl
    import hpd_pkg::*;
(
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire logic                 CE_N_IN,
    input  wire logic                 OE_N_IN,
    input  wire logic                 WE_N_IN,
    input  wire logic [15:0]          ADDR_IN,
    input  wire logic [15:0]          DATA_IN,
    input  wire logic                 DEVICE_ID_IN,
    input  wire logic                 ASYNC_BOOT_IN,
    input  wire logic                 DATA_READY_IN,
    input  wire logic                 WORD_DONE_IN,
    input  wire logic [15:0]          BLOCK_WORDS_IN,
    input  wire logic                 PROT_ACCESS_IN,
    input  wire logic [15:0]          FLASH_DATA_IN,
    output logic [15:0]               DATA_OUT,
    output logic                      DATA_OE_OUT,
    output logic                      TRANSFER_REQUEST_OUT,
    output logic                      TRANSFER_REQUEST_OE_OUT,
    output logic                      PROT_GRANT_OUT,
    output logic                      LOCK_OUT,
    output logic                      DEEP_SLEEP_OUT,
    output logic                      SWAP_OUT,
    output logic                      STROBE_CLOCK_OUT,
    output logic [hpd_pkg::FLASH_AW-1:0] FLASH_ADDR_OUT
);
    localparam int PW = 37;

    logic [PW-1:0]       sync1_ff;
    logic [PW-1:0]       sync2_ff;
    logic [PW-1:0]       prev_ff;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [15:0]         addr;
    logic [15:0]         wdata;
    logic                dev_id;
    logic                boot_strap;
    logic                p_ce_n;
    logic                p_we_n;
    logic [15:0]         p_addr;
    logic [15:0]         p_data;
    logic                wr_ev;
    logic                wake_ev;
    logic                wake_sel_ff;
    logic                sleep_ff;
    logic                dma_en_ff;
    logic                request_polarity_ff;
    logic                dma_edge_ff;
    logic [DMA_PW_W-1:0] dma_pw_ff;
    logic [NEG_W-1:0]    neg_ff;
    logic                lock_ff;
    logic                swap_ff;
    logic                unlock_ff;
    logic                start_full;
    logic                start_seq;
    logic                ldr_busy;
    logic [15:0]         ram_data;
    logic                req_active;
    logic                req_pin_ff;
    logic                req_oe_ff;
    logic                grant_ff;
    logic [15:0]         dout_ff;
    logic                doe_ff;
    logic [1:0]          init_cnt_ff;
    logic                strobe_clk_ff;
    logic [15:0]         nxt_dout;

    assign ce_n       = sync2_ff[0];
    assign oe_n       = sync2_ff[1];
    assign we_n       = sync2_ff[2];
    assign addr       = sync2_ff[18:3];
    assign wdata      = sync2_ff[34:19];
    assign dev_id     = sync2_ff[35];
    assign boot_strap = sync2_ff[36];
    assign p_ce_n     = prev_ff[0];
    assign p_we_n     = prev_ff[2];
    assign p_addr     = prev_ff[18:3];
    assign p_data     = prev_ff[34:19];

    // every bus and strap pin passes two flops; the write is taken on the rising write strobe
    // using the address and data from the cycle before, which were still stable
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            sync1_ff <= {{(PW-3){1'b0}}, 3'b111};
            sync2_ff <= {{(PW-3){1'b0}}, 3'b111};
            prev_ff  <= {{(PW-3){1'b0}}, 3'b111};
        end
        else
        begin
            sync1_ff <= {ASYNC_BOOT_IN, DEVICE_ID_IN, DATA_IN, ADDR_IN,
                         WE_N_IN, OE_N_IN, CE_N_IN};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // a sleeping device takes no writes
    assign wr_ev = we_n && !p_we_n && !p_ce_n && !sleep_ff;

    always_comb
    begin
        if (wake_sel_ff)
            wake_ev = !ce_n && (!oe_n || !we_n);
        else
            wake_ev = !ce_n;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            sleep_ff <= 1'b0;
        else if (sleep_ff && wake_ev)
            sleep_ff <= 1'b0;
        else if (wr_ev && p_addr == OFS_SLEEP_TRIG && p_data[SLEEP_TRIG_BIT])
            sleep_ff <= 1'b1;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            wake_sel_ff <= 1'b0;
            dma_en_ff   <= 1'b0;
            request_polarity_ff  <= POL_RST;
            dma_edge_ff <= 1'b0;
            dma_pw_ff   <= PW_RST;
            neg_ff      <= NEG_RST;
        end
        else if (wr_ev)
        begin
            if (p_addr == OFS_WAKE_SEL)
                wake_sel_ff <= p_data[WAKE_SEL_BIT];
            if (p_addr == OFS_DMA_CTRL)
            begin
                dma_en_ff   <= p_data[DMA_EN_BIT];
                request_polarity_ff  <= p_data[REQUEST_POLARITY_BIT];
                dma_edge_ff <= p_data[DMA_EDGE_BIT];
                dma_pw_ff   <= p_data[DMA_PW_LSB +: DMA_PW_W];
            end
            if (p_addr == OFS_DMA_NEG)
                neg_ff <= p_data[NEG_W-1:0];
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            lock_ff <= 1'b0;
        else if (wr_ev && p_addr == OFS_LOCK && p_data[LOCK_BIT])
            lock_ff <= 1'b1;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            grant_ff <= 1'b0;
        else
            grant_ff <= PROT_ACCESS_IN && !lock_ff;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            swap_ff <= 1'b0;
        else if (wr_ev && p_addr == OFS_SWAP)
            swap_ff <= p_data[SWAP_LO_BIT] || p_data[SWAP_HI_BIT];
    end

    // any other write between unlock and page select voids the unlock
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            unlock_ff <= 1'b0;
        else if (wr_ev)
            unlock_ff <= p_addr == OFS_PAGE_CMD && p_data[7:0] == UNLOCK_CODE;
    end

    // direct select supports page 0 only, repeating the reset preload; bit 7 set loads the next page
    assign start_full = wr_ev && p_addr == OFS_PAGE_SEL && unlock_ff && !dev_id
                        && !p_data[SEQ_BIT] && p_data[PAGE_W-1:0] == '0;
    assign start_seq  = wr_ev && p_addr == OFS_PAGE_SEL && unlock_ff && !dev_id
                        && p_data[SEQ_BIT];

    hpd_page_loader u_loader
    (
        .clk_in         (CLK_IN),
        .rst_n_in       (RST_N_IN),
        .full_in        (start_full),
        .seq_in         (start_seq),
        .rd_idx_in      (addr[10:1]),
        .flash_data_in  (FLASH_DATA_IN),
        .rd_data_out    (ram_data),
        .flash_addr_out (FLASH_ADDR_OUT),
        .busy_out       (ldr_busy)
    );

    hpd_dma_req u_dma
    (
        .clk_in         (CLK_IN),
        .rst_n_in       (RST_N_IN),
        .ready_in       (DATA_READY_IN),
        .word_in        (WORD_DONE_IN),
        .block_words_in (BLOCK_WORDS_IN),
        .width_in       (dma_pw_ff),
        .edge_in        (dma_edge_ff),
        .neg_in         (neg_ff),
        .active_out     (req_active)
    );

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            req_pin_ff <= POL_RST;
            req_oe_ff  <= 1'b0;
        end
        else
        begin
            req_pin_ff <= req_active ^ request_polarity_ff;
            req_oe_ff  <= dma_en_ff;
        end
    end

    // read data: registers are not swapped, only the RAM data path is
    always_comb
    begin
        nxt_dout = 16'h0000;
        case (addr)
            OFS_WAKE_SEL:   nxt_dout[WAKE_SEL_BIT] = wake_sel_ff;
            OFS_DMA_CTRL:
            begin
                nxt_dout[DMA_EN_BIT]                 = dma_en_ff;
                nxt_dout[REQUEST_POLARITY_BIT]                = request_polarity_ff;
                nxt_dout[DMA_EDGE_BIT]               = dma_edge_ff;
                nxt_dout[DMA_PW_LSB +: DMA_PW_W]     = dma_pw_ff;
            end
            OFS_DMA_NEG:    nxt_dout[NEG_W-1:0] = neg_ff;
            OFS_LOCK:       nxt_dout[LOCK_BIT] = lock_ff;
            OFS_SWAP:
            begin
                nxt_dout[SWAP_LO_BIT] = swap_ff;
                nxt_dout[SWAP_HI_BIT] = swap_ff;
            end
            OFS_LDR_STATUS: nxt_dout[0] = ldr_busy;
            default:
            begin
                if (addr < RAM_BYTES)
                    nxt_dout = swap_ff ? {ram_data[7:0], ram_data[15:8]} : ram_data;
            end
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            dout_ff <= 16'h0000;
            doe_ff  <= 1'b0;
        end
        else
        begin
            dout_ff <= nxt_dout;
            doe_ff  <= !ce_n && !oe_n && !sleep_ff;
        end
    end

    // strap is taken once the synchroniser has filled; the boot fetch ends
    // when the host releases chip enable after its first burst
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            init_cnt_ff   <= 2'b00;
            strobe_clk_ff <= 1'b1;
        end
        else if (init_cnt_ff != 2'b11)
        begin
            init_cnt_ff   <= init_cnt_ff + 2'b01;
            strobe_clk_ff <= !(init_cnt_ff == 2'b10 && boot_strap);
        end
        else if (!strobe_clk_ff && ce_n && !p_ce_n)
            strobe_clk_ff <= 1'b1;
    end

    assign DATA_OUT                = dout_ff;
    assign DATA_OE_OUT             = doe_ff;
    assign TRANSFER_REQUEST_OUT    = req_pin_ff;
    assign TRANSFER_REQUEST_OE_OUT = req_oe_ff;
    assign PROT_GRANT_OUT          = grant_ff;
    assign LOCK_OUT                = lock_ff;
    assign DEEP_SLEEP_OUT          = sleep_ff;
    assign SWAP_OUT                = swap_ff;
    assign STROBE_CLOCK_OUT        = strobe_clk_ff;

    wake_ce_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        sleep_ff && !wake_sel_ff && !ce_n |=> !sleep_ff)
        else $error("chip enable did not wake the device");

    wake_full_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        sleep_ff && wake_sel_ff && oe_n && we_n |=> sleep_ff)
        else $error("woke without a full access");

    sleep_entry_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !sleep_ff && wr_ev && p_addr == OFS_SLEEP_TRIG && p_data[0] |=> sleep_ff)
        else $error("trigger write did not enter deep sleep");

    lock_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        lock_ff |=> lock_ff [*4])
        else $error("sticky lock cleared without reset");

    lock_deny_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        lock_ff |=> !PROT_GRANT_OUT)
        else $error("protected access granted under lock");

    swap_set_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_ev && p_addr == OFS_SWAP |=> swap_ff == $past(p_data[0] || p_data[8]))
        else $error("swap state does not follow bit 0 or bit 8");

    unlock_need_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !unlock_ff |-> !start_full && !start_seq)
        else $error("page download started without unlock");

    cascade_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        dev_id |-> !start_full && !start_seq)
        else $error("download started in second cascaded device");

    req_gate_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        ##1 TRANSFER_REQUEST_OE_OUT == $past(dma_en_ff)
        && TRANSFER_REQUEST_OUT == $past(req_active ^ request_polarity_ff))
        else $error("request pin level or enable wrong");

endmodule : hpd_host_ctrl

// ### src/hpd_pkg.sv
package hpd_pkg;

    // host window byte offsets
    localparam logic [15:0] OFS_WAKE_SEL    = 16'h940c;
    localparam logic [15:0] OFS_DMA_CTRL    = 16'h940e;
    localparam logic [15:0] OFS_LOCK        = 16'h9410;
    localparam logic [15:0] OFS_SWAP        = 16'h9412;
    localparam logic [15:0] OFS_SLEEP_TRIG  = 16'h9416;
    localparam logic [15:0] OFS_DMA_NEG     = 16'h9418;
    localparam logic [15:0] OFS_LDR_STATUS  = 16'h941a;
    localparam logic [15:0] OFS_PAGE_CMD    = 16'h0030;
    localparam logic [15:0] OFS_PAGE_SEL    = 16'h0070;
    localparam logic [15:0] RAM_BYTES       = 16'h0800;

    // field positions
    localparam int WAKE_SEL_BIT   = 8;
    localparam int SLEEP_TRIG_BIT = 0;
    localparam int DMA_EN_BIT     = 0;
    localparam int REQUEST_POLARITY_BIT    = 1;
    localparam int DMA_EDGE_BIT   = 2;
    localparam int DMA_PW_LSB     = 4;
    localparam int DMA_PW_W       = 5;
    localparam int NEG_W          = 10;
    localparam int LOCK_BIT       = 0;
    localparam int SWAP_LO_BIT    = 0;
    localparam int SWAP_HI_BIT    = 8;
    localparam int SEQ_BIT        = 7;
    localparam int PAGE_W         = 7;

    // reset values
    localparam logic [4:0] PW_RST   = 5'h04;
    localparam logic       POL_RST  = 1'b1;
    localparam logic [9:0] NEG_RST  = 10'h004;

    // paged loader
    localparam logic [7:0] UNLOCK_CODE = 8'h71;
    localparam int         RAM_WORDS   = 1024;
    localparam int         HALF_WORDS  = 512;
    localparam logic [7:0] MAX_PAGES   = 8'hfe;
    localparam logic [7:0] PAGES_AFTER_PRELOAD = 8'h02;
    localparam int         FLASH_AW    = 17;

    typedef enum logic [1:0]
    {
        LDR_IDLE = 2'b00,
        LDR_FULL = 2'b01,
        LDR_PAGE = 2'b10
    } hpd_ldr_state_t;

endpackage : hpd_pkg

// ### src/hpd_dma_req.sv
`timescale 1ns/1ps
module hpd_dma_req
    import hpd_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                ready_in,
    input  wire logic                word_in,
    input  wire logic [15:0]         block_words_in,
    input  wire logic [DMA_PW_W-1:0] width_in,
    input  wire logic                edge_in,
    input  wire logic [NEG_W-1:0]    neg_in,
    output logic                     active_out
);
    logic                active_ff;
    logic                edge_ff;
    logic [DMA_PW_W-1:0] cnt_ff;
    logic [DMA_PW_W-1:0] wlat_ff;
    logic [15:0]         done_ff;
    logic [DMA_PW_W-1:0] hi_cnt_ff;

    assign active_out = active_ff;

    // mode and width are latched per request so a mid-request write to OFS_DMA_CTRL cannot cut it
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            active_ff <= 1'b0;
            edge_ff   <= 1'b0;
            cnt_ff    <= '0;
            wlat_ff   <= '0;
        end
        else if (!active_ff)
        begin
            if (ready_in && width_in != '0)
            begin
                active_ff <= 1'b1;
                edge_ff   <= edge_in;
                cnt_ff    <= width_in;
                wlat_ff   <= width_in;
            end
        end
        else if (edge_ff)
        begin
            if (cnt_ff == 5'h01)
                active_ff <= 1'b0;
            cnt_ff <= cnt_ff - 5'h01;
        end
        else if (block_words_in - done_ff == {6'h00, neg_in})
            active_ff <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            done_ff <= '0;
        else if (!active_ff && ready_in)
            done_ff <= '0;
        else if (word_in)
            done_ff <= done_ff + 16'h0001;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !active_ff)
            hi_cnt_ff <= 5'h01;
        else
            hi_cnt_ff <= hi_cnt_ff + 5'h01;
    end

    pulse_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(active_ff) && edge_ff |-> $past(hi_cnt_ff) == wlat_ff)
        else $error("edge request length differs from programmed width");

    zero_width_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !active_ff && width_in == '0 |=> !active_ff)
        else $error("request asserted with zero width");

endmodule : hpd_dma_req

// ### src/hpd_page_loader.sv
`timescale 1ns/1ps
module hpd_page_loader
    import hpd_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                full_in,
    input  wire logic                seq_in,
    input  wire logic [9:0]          rd_idx_in,
    input  wire logic [15:0]         flash_data_in,
    output logic [15:0]              rd_data_out,
    output logic [FLASH_AW-1:0]      flash_addr_out,
    output logic                     busy_out
);
    logic [15:0]         mem [0:RAM_WORDS-1];
    hpd_ldr_state_t      state_ff;
    logic [9:0]          idx_ff;
    logic [9:0]          wr_idx_ff;
    logic                wr_valid_ff;
    logic [7:0]          next_page_ff;
    logic [FLASH_AW-1:0] flash_addr_ff;
    logic [15:0]         rd_data_ff;

    assign flash_addr_out = flash_addr_ff;
    assign rd_data_out    = rd_data_ff;
    assign busy_out       = (state_ff != LDR_IDLE) || wr_valid_ff;

    // reset lands in the preload state: first 2KB copied before anything else
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_ff      <= LDR_FULL;
            idx_ff        <= '0;
            wr_idx_ff     <= '0;
            wr_valid_ff   <= 1'b0;
            next_page_ff  <= '0;
            flash_addr_ff <= '0;
        end
        else
        begin
            wr_valid_ff <= 1'b0;
            case (state_ff)
                LDR_IDLE:
                begin
                    idx_ff <= '0;
                    if (full_in)
                        state_ff <= LDR_FULL;
                    else if (seq_in && next_page_ff < MAX_PAGES)
                        state_ff <= LDR_PAGE;
                end
                LDR_FULL:
                begin
                    flash_addr_ff <= {7'h00, idx_ff};
                    wr_idx_ff     <= idx_ff;
                    wr_valid_ff   <= 1'b1;
                    idx_ff        <= idx_ff + 10'h001;
                    if (idx_ff == 10'(RAM_WORDS - 1))
                    begin
                        state_ff     <= LDR_IDLE;
                        next_page_ff <= PAGES_AFTER_PRELOAD;
                    end
                end
                LDR_PAGE:
                begin
                    // constant half stays untouched, pages land in the upper half
                    flash_addr_ff <= {next_page_ff, idx_ff[8:0]};
                    wr_idx_ff     <= {1'b1, idx_ff[8:0]};
                    wr_valid_ff   <= 1'b1;
                    idx_ff        <= idx_ff + 10'h001;
                    if (idx_ff == 10'(HALF_WORDS - 1))
                    begin
                        state_ff     <= LDR_IDLE;
                        next_page_ff <= next_page_ff + 8'h01;
                    end
                end
                default:
                    state_ff <= LDR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (wr_valid_ff)
            mem[wr_idx_ff] <= flash_data_in;
        rd_data_ff <= mem[rd_idx_in];
    end

    upper_half_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_ff == LDR_PAGE |=> wr_valid_ff && wr_idx_ff[9])
        else $error("page download wrote the constant half");

endmodule : hpd_page_loader

// ### verif/hpd_host_model.sv
`timescale 1ns/1ps
module hpd_host_model
    import hpd_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic [FLASH_AW-1:0] flash_addr_in,
    input  wire logic                req_in,
    output logic [15:0]              flash_data_out,
    output logic                     word_done_out
);
    // each image word depends on its address, so a misplaced word shows up
    assign flash_data_out = flash_addr_in[15:0] ^ 16'h3c3c;
    initial word_done_out = 1'b0;
    // takes one word per cycle while its active-high request is seen
    always @(posedge clk_in)
    begin
        word_done_out <= req_in;
    end
endmodule : hpd_host_model

// ### verif/host_power_dma_lock_boot_ctrl_tb.sv
`timescale 1ns/1ps
module host_power_dma_lock_boot_ctrl_tb;
    import hpd_pkg::*;
    logic                CLK_IN = 0, RST_N_IN = 0, CE_N_IN = 1, OE_N_IN = 1, WE_N_IN = 1;
    logic                DEVICE_ID_IN = 0, ASYNC_BOOT_IN = 0, DATA_READY_IN = 0;
    logic                PROT_ACCESS_IN = 0, WORD_DONE_IN, DATA_OE_OUT, TRANSFER_REQUEST_OUT;
    logic                TRANSFER_REQUEST_OE_OUT, PROT_GRANT_OUT, LOCK_OUT, DEEP_SLEEP_OUT;
    logic                SWAP_OUT, STROBE_CLOCK_OUT;
    logic [15:0]         ADDR_IN = 0, DATA_IN = 0, BLOCK_WORDS_IN = 16'h0008;
    logic [15:0]         FLASH_DATA_IN, DATA_OUT, rd;
    logic [FLASH_AW-1:0] FLASH_ADDR_OUT;
    logic [15:0]         mdl [int];
    logic [15:0]         sw [3] = '{16'h0100, 16'h0001, 16'h0000};
    int                  failures = 0, checks = 0, cycles = 0, n, w;

    hpd_host_ctrl uut (.CLK_IN, .RST_N_IN, .CE_N_IN, .OE_N_IN, .WE_N_IN, .ADDR_IN, .DATA_IN,
        .DEVICE_ID_IN, .ASYNC_BOOT_IN, .DATA_READY_IN, .WORD_DONE_IN, .BLOCK_WORDS_IN,
        .PROT_ACCESS_IN, .FLASH_DATA_IN, .DATA_OUT, .DATA_OE_OUT, .TRANSFER_REQUEST_OUT,
        .TRANSFER_REQUEST_OE_OUT, .PROT_GRANT_OUT, .LOCK_OUT, .DEEP_SLEEP_OUT, .SWAP_OUT,
        .STROBE_CLOCK_OUT, .FLASH_ADDR_OUT);
    hpd_host_model host (.clk_in(CLK_IN), .flash_addr_in(FLASH_ADDR_OUT),
        .req_in(TRANSFER_REQUEST_OE_OUT & TRANSFER_REQUEST_OUT),
        .flash_data_out(FLASH_DATA_IN), .word_done_out(WORD_DONE_IN));

    initial forever #2.5 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            end_of_test();
        end
    end

    task end_of_test();
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(negedge CLK_IN);
    endtask : cyc
    // the model follows every write except those to the page command, page select and sleep trigger; writes are never issued while asleep
    task wr(input logic [15:0] a, input logic [15:0] d);
        ADDR_IN = a; DATA_IN = d; CE_N_IN = 0; WE_N_IN = 0; cyc(4);
        WE_N_IN = 1; cyc(1); CE_N_IN = 1; cyc(4);
        case (a)
            OFS_WAKE_SEL: mdl[a] = d & 16'h0100;
            OFS_DMA_CTRL: mdl[a] = d & 16'h01f7;
            OFS_LOCK:     mdl[a] = mdl[a] | (d & 16'h0001);
            OFS_SWAP:     mdl[a] = ((d & 16'h0101) != 0) ? 16'h0101 : 16'h0000;
            OFS_DMA_NEG:  mdl[a] = d & 16'h03ff;
            default: ;
        endcase
    endtask : wr
    task rdw(input logic [15:0] a);
        ADDR_IN = a; CE_N_IN = 0; OE_N_IN = 0; cyc(6);
        rd = DATA_OUT;
        chk("data oe", 16'h0001, {15'h0, DATA_OE_OUT});
        CE_N_IN = 1; OE_N_IN = 1; cyc(3);
    endtask : rdw
    // polling only touches the status register, never the loader ram
    task poll();
        for (n = 0; n < 400; n++)
        begin
            rdw(OFS_LDR_STATUS);
            if (rd[0] === 1'b0) break;
        end
        chk("loader busy", 16'h0000, rd & 16'h0001);
    endtask : poll
    task regs();
        foreach (mdl[k])
        begin
            rdw(16'(k));
            chk($sformatf("reg %h", k), mdl[k], rd);
        end
    endtask : regs
    task pulse(input int ew);
        DATA_READY_IN = 1; cyc(1); DATA_READY_IN = 0; n = 0;
        repeat (40) begin cyc(1); if (TRANSFER_REQUEST_OUT === 1'b1) n++; end
        chk("request width", 16'(ew), 16'(n));
    endtask : pulse

    initial
    begin
        void'($urandom(87933));
        cyc(20); RST_N_IN = 1; cyc(3);
        mdl[OFS_WAKE_SEL] = 0; mdl[OFS_DMA_CTRL] = 16'h0042; mdl[OFS_LOCK] = 0;
        mdl[OFS_SWAP] = 0; mdl[OFS_SLEEP_TRIG] = 0; mdl[OFS_DMA_NEG] = 16'h0004;
        mdl[16'h9420] = 0;
        chk("req pin", 16'h0001, {15'h0, TRANSFER_REQUEST_OUT});
        chk("req oe", 16'h0000, {15'h0, TRANSFER_REQUEST_OE_OUT});
        poll();
        rdw(16'h0000); chk("ram first", 16'h3c3c, rd);
        rdw(16'h07fe); chk("ram last", 16'h3fc3, rd);
        wr(OFS_PAGE_SEL, 16'h0080); rdw(16'h0400); chk("no unlock", 16'h3e3c, rd);
        wr(OFS_PAGE_CMD, 16'h0071); wr(OFS_PAGE_SEL, 16'h0085); poll();
        rdw(16'h0400); chk("next page", 16'h383c, rd);
        rdw(16'h0000); chk("const half", 16'h3c3c, rd);
        // second device in a cascade must ignore the command, first device redoes the preload
        DEVICE_ID_IN = 1; wr(OFS_PAGE_CMD, 16'h0071); wr(OFS_PAGE_SEL, 16'h0000); poll();
        rdw(16'h0400); chk("cascade", 16'h383c, rd);
        DEVICE_ID_IN = 0; wr(OFS_PAGE_CMD, 16'h0071); wr(OFS_PAGE_SEL, 16'h0000); poll();
        rdw(16'h0400); chk("page zero", 16'h3e3c, rd);
        regs();
        foreach (sw[i])
        begin
            wr(OFS_SWAP, sw[i]); rdw(16'h07fe);
            chk("swap data", (sw[i] != 0) ? 16'hc33f : 16'h3fc3, rd);
            chk("swap pin", {15'h0, sw[i] != 0}, {15'h0, SWAP_OUT});
        end
        PROT_ACCESS_IN = 1; cyc(3);
        chk("grant open", 16'h0001, {15'h0, PROT_GRANT_OUT});
        wr(OFS_LOCK, 16'h0001); wr(OFS_LOCK, 16'h0000);
        chk("lock pin", 16'h0001, {15'h0, LOCK_OUT});
        chk("grant shut", 16'h0000, {15'h0, PROT_GRANT_OUT});
        w = $urandom_range(31, 1);
        wr(OFS_DMA_CTRL, 16'(w * 16 + 5));
        chk("req oe on", 16'h0001, {15'h0, TRANSFER_REQUEST_OE_OUT});
        chk("req idle", 16'h0000, {15'h0, TRANSFER_REQUEST_OUT});
        pulse(w);
        wr(OFS_DMA_CTRL, 16'h0005); pulse(0);
        wr(OFS_DMA_NEG, 16'h0002);
        // level: negation after block minus count words; pin, host and word count add a cycle each
        wr(OFS_DMA_CTRL, 16'h0041); pulse(int'(BLOCK_WORDS_IN) - 2 + 3);
        regs();
        wr(OFS_WAKE_SEL, 16'h0100); wr(OFS_SLEEP_TRIG, 16'h0001);
        chk("asleep", 16'h0001, {15'h0, DEEP_SLEEP_OUT});
        CE_N_IN = 0; cyc(5);
        chk("ce only", 16'h0001, {15'h0, DEEP_SLEEP_OUT});
        CE_N_IN = 1; cyc(3); rdw(OFS_WAKE_SEL);
        chk("read wake", 16'h0000, {15'h0, DEEP_SLEEP_OUT});
        wr(OFS_WAKE_SEL, 16'h0000); wr(OFS_SLEEP_TRIG, 16'h0001);
        chk("asleep again", 16'h0001, {15'h0, DEEP_SLEEP_OUT});
        CE_N_IN = 0; cyc(5); CE_N_IN = 1;
        chk("ce wake", 16'h0000, {15'h0, DEEP_SLEEP_OUT});
        cyc(3);
        regs();
        // mid-run reset with the async boot strap high: lock clears, strobe clocking waits
        ASYNC_BOOT_IN = 1; RST_N_IN = 0; cyc(4); RST_N_IN = 1; cyc(5);
        chk("lock reset", 16'h0000, {15'h0, LOCK_OUT});
        chk("grant reset", 16'h0001, {15'h0, PROT_GRANT_OUT});
        chk("req pin reset", 16'h0001, {15'h0, TRANSFER_REQUEST_OUT});
        chk("boot clock", 16'h0000, {15'h0, STROBE_CLOCK_OUT});
        rdw(16'h0000); cyc(2);
        chk("strobe clock", 16'h0001, {15'h0, STROBE_CLOCK_OUT});
        end_of_test();
    end
endmodule : host_power_dma_lock_boot_ctrl_tb
